// ===== pkg/cmpms_params.svh
/*
 Register addresses, field positions, reset values and input codes
 for the comparator mode and input select bank.
 Assumes inclusion by bare name from the core file and the testbench.
*/
`ifndef CMPMS_PARAMS_SVH
`define CMPMS_PARAMS_SVH

// SFR addresses
`define CMPMS_ADDR_MODE 8'h9c
`define CMPMS_ADDR_MUX 8'h9f

// Reset values
`define CMPMS_RST_MODE 8'h82
`define CMPMS_RST_MUX 8'hff

// Mode register fields
`define CMPMS_FIXED_HI 7
`define CMPMS_RIE 5
`define CMPMS_FIE 4
`define CMPMS_MD_HI 1
`define CMPMS_MD_LO 0
`define CMPMS_ZERO_BIT 6
`define CMPMS_ZERO_HI 3
`define CMPMS_ZERO_LO 2

// Two synchroniser stages plus the edge compare stage
`define CMPMS_SYNC_DEPTH 3

// Input select fields
`define CMPMS_NEG_HI 7
`define CMPMS_NEG_LO 4
`define CMPMS_POS_HI 3
`define CMPMS_POS_LO 0

// Input codes
`define CMPMS_CODE_TOUCH 4'hc
`define CMPMS_CODE_HALF 4'hd

// One bit per code that names a port pin
`define CMPMS_NEG_PIN_MASK 16'h07cf
`define CMPMS_POS_PIN_MASK 16'h0f8f

// Value of an unmapped read
`define CMPMS_RD_NONE 8'h00

`endif

// ===== pkg/cmpms_pkg.sv
/*
 Types shared by the comparator mode and input select bank.
 Assumes cmpms_params.svh is on the include path.
*/
package cmpms_pkg;

    // Response and power modes
    typedef enum logic [1:0] {
        CMPMS_MODE_FAST,
        CMPMS_MODE_MID1,
        CMPMS_MODE_MID2,
        CMPMS_MODE_SLOW
    } cmpms_speed_t;

    // Stored fields of the mode register
    typedef struct packed {
        logic rise_edge_irq_enable;
        logic fall_edge_irq_enable;
        cmpms_speed_t response_power_mode;
    } cmpms_mode_t;

    // Input select register
    typedef struct packed {
        logic [3:0] negative_input_select;
        logic [3:0] positive_input_select;
    } cmpms_mux_t;

endpackage

// ===== core/cmpms_top.sv
/*
 Comparator mode and input select register bank: comparator 1 mode
 register, comparator 0 input select register, comparator 1 edge
 flags and interrupt request, capture routing and mux side controls.
 Assumes a single-cycle SFR bus on REF_CLK, comparator outputs that
 arrive asynchronously, and timer logic that picks its capture source.
*/
// How it works
// - Mode bit 7 always reads one.
// - Mode bits 6, 3:2 read zero.
// - Bit 5 enables rising-edge interrupt.
// - Bit 4 enables falling-edge interrupt.
// - Bits 1:0 choose speed/power mode.
// - Bits 7:4 choose negative input.
// - Bits 3:0 choose positive input.
// - Comparator outputs feed either timer capture.
// - Touch code connects opposite pin directly.
// - Half-supply divider on only when selected.
// - Edges set flags; software clears them.
`timescale 1ns/1ps
`include "cmpms_params.svh"

module cmpms_top #(
    parameter int N_CAP = 2
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // SFR bus
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    output logic SFR_RHIT,
    // Analogue comparator outputs
    input wire logic CMP0_OUT,
    input wire logic CMP1_OUT,
    // Edge flag clears from software
    input wire logic RISE_FLAG_CLR,
    input wire logic FALL_FLAG_CLR,
    // Timer capture source selects, 1 picks comparator 1
    input wire logic [N_CAP-1:0] CAP_SRC_SEL,
    // Configuration towards the analogue side
    output cmpms_pkg::cmpms_mode_t CMP1_MODE,
    output cmpms_pkg::cmpms_mux_t CMP0_MUX,
    output logic TOUCH_NEG_PIN_EN,
    output logic TOUCH_POS_PIN_EN,
    output logic HALF_DIV_EN,
    // Edge flags, interrupt and capture
    output logic RISE_FLAG,
    output logic FALL_FLAG,
    output logic CMP1_IRQ,
    output logic [N_CAP-1:0] TMR_CAP
);
    import cmpms_pkg::*;

    // Between one and four timers can take a capture route
    if (N_CAP < 1 || N_CAP > 4) begin : g_bad_n_cap
        $error("N_CAP must be 1 to 4");
    end

    // Address hits
    wire hit_mode = (SFR_ADDR == `CMPMS_ADDR_MODE);
    wire hit_mux = (SFR_ADDR == `CMPMS_ADDR_MUX);
    wire wr_mode = SFR_WR && hit_mode;
    wire wr_mux = SFR_WR && hit_mux;

    // Write data mapped onto fields; bits 7, 6, 3:2 are dropped
    wire cmpms_mode_t wr_mode_val = '{
        rise_edge_irq_enable: SFR_WDATA[`CMPMS_RIE],
        fall_edge_irq_enable: SFR_WDATA[`CMPMS_FIE],
        response_power_mode:
            cmpms_speed_t'(SFR_WDATA[`CMPMS_MD_HI:`CMPMS_MD_LO])
    };
    wire cmpms_mux_t wr_mux_val = '{
        negative_input_select: SFR_WDATA[`CMPMS_NEG_HI:`CMPMS_NEG_LO],
        positive_input_select: SFR_WDATA[`CMPMS_POS_HI:`CMPMS_POS_LO]
    };

    // Reset image of the mode register
    localparam logic [7:0] RST_MODE = `CMPMS_RST_MODE;
    wire cmpms_mode_t rst_mode_val = '{
        rise_edge_irq_enable: RST_MODE[`CMPMS_RIE],
        fall_edge_irq_enable: RST_MODE[`CMPMS_FIE],
        response_power_mode:
            cmpms_speed_t'(RST_MODE[`CMPMS_MD_HI:`CMPMS_MD_LO])
    };

    // Read view: bit 7 fixed high, unused bits fixed low
    wire [7:0] mode_view = {
        1'b1,
        1'b0,
        CMP1_MODE.rise_edge_irq_enable,
        CMP1_MODE.fall_edge_irq_enable,
        2'b00,
        CMP1_MODE.response_power_mode
    };
    wire [7:0] next_rdata = hit_mode ? mode_view
        : hit_mux ? CMP0_MUX
        : `CMPMS_RD_NONE;
    wire next_rhit = hit_mode || hit_mux;

    // Register writes
    // Bits 7, 6 and 3:2 have no storage; the read view supplies them
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            CMP1_MODE <= rst_mode_val;
            CMP0_MUX <= `CMPMS_RST_MUX;
        end else begin
            if (wr_mode) begin
                CMP1_MODE <= wr_mode_val;
            end
            if (wr_mux) begin
                CMP0_MUX <= wr_mux_val;
            end
        end
    end

    // Read data held until the next read
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            SFR_RDATA <= `CMPMS_RD_NONE;
            SFR_RHIT <= 1'b0;
        end else if (SFR_RD) begin
            SFR_RDATA <= next_rdata;
            SFR_RHIT <= next_rhit;
        end
    end

    // Comparator outputs are asynchronous; two flops before use
    logic [1:0] cmp_meta;
    logic [1:0] cmp_sync;
    logic [1:0] cmp_prev;
    // Fill marker, one stage per flop between pin and edge compare
    logic [`CMPMS_SYNC_DEPTH-1:0] sync_fill;
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            cmp_meta <= 2'h0;
            cmp_sync <= 2'h0;
            cmp_prev <= 2'h0;
            sync_fill <= '0;
        end else begin
            cmp_meta <= {CMP1_OUT, CMP0_OUT};
            cmp_sync <= cmp_meta;
            cmp_prev <= cmp_sync;
            sync_fill <= {sync_fill[`CMPMS_SYNC_DEPTH-2:0], 1'b1};
        end
    end

    // Reset zeros stand in for pin samples until the chain has filled;
    // without this a comparator already high at release looks like a rise
    wire sync_ready = sync_fill[`CMPMS_SYNC_DEPTH-1];

    // Comparator 1 edges, only once both compare stages hold pin samples
    wire rise_evt = sync_ready && cmp_sync[1] && !cmp_prev[1];
    wire fall_evt = sync_ready && !cmp_sync[1] && cmp_prev[1];

    // Flags: a set in the clear cycle wins, so no edge is lost
    wire next_rise = rise_evt || (RISE_FLAG && !RISE_FLAG_CLR);
    wire next_fall = fall_evt || (FALL_FLAG && !FALL_FLAG_CLR);

    // Request from flags gated by their enables
    wire next_irq = (RISE_FLAG && CMP1_MODE.rise_edge_irq_enable)
        || (FALL_FLAG && CMP1_MODE.fall_edge_irq_enable);

    // Flags and interrupt
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            RISE_FLAG <= 1'b0;
            FALL_FLAG <= 1'b0;
            CMP1_IRQ <= 1'b0;
        end else begin
            RISE_FLAG <= next_rise;
            FALL_FLAG <= next_fall;
            CMP1_IRQ <= next_irq;
        end
    end

    // Capture routing, one selector per timer
    genvar gi;
    generate
        for (gi = 0; gi < N_CAP; gi++) begin : g_cap
            wire cap_src = CAP_SRC_SEL[gi] ? cmp_sync[1] : cmp_sync[0];
            always_ff @(posedge REF_CLK) begin
                if (!NRST) begin
                    TMR_CAP[gi] <= 1'b0;
                end else begin
                    TMR_CAP[gi] <= cap_src;
                end
            end
        end
    endgenerate

    // Mux side controls decoded from the stored selects
    wire [3:0] neg_sel = CMP0_MUX.negative_input_select;
    wire [3:0] pos_sel = CMP0_MUX.positive_input_select;
    localparam logic [15:0] NEG_PINS = `CMPMS_NEG_PIN_MASK;
    localparam logic [15:0] POS_PINS = `CMPMS_POS_PIN_MASK;
    wire neg_is_pin = NEG_PINS[neg_sel];
    wire pos_is_pin = POS_PINS[pos_sel];
    // Pin on one side goes straight to the sense path when other is touch
    wire next_touch_neg = (pos_sel == `CMPMS_CODE_TOUCH) && neg_is_pin;
    wire next_touch_pos = (neg_sel == `CMPMS_CODE_TOUCH) && pos_is_pin;
    // Divider only draws current while a side selects it
    wire next_half = (neg_sel == `CMPMS_CODE_HALF)
        || (pos_sel == `CMPMS_CODE_HALF);

    // Side controls lag the select by one cycle
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            TOUCH_NEG_PIN_EN <= 1'b0;
            TOUCH_POS_PIN_EN <= 1'b0;
            HALF_DIV_EN <= 1'b0;
        end else begin
            TOUCH_NEG_PIN_EN <= next_touch_neg;
            TOUCH_POS_PIN_EN <= next_touch_pos;
            HALF_DIV_EN <= next_half;
        end
    end

    // Checks on the bank
    // They sleep while reset is low; the synchronous reset owns those edges
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    a_mode_bit7_one: assert property (
        SFR_RD && hit_mode |=> SFR_RDATA[`CMPMS_FIXED_HI])
        else $error("mode bit 7 read as zero");

    a_unused_bits_zero: assert property (
        SFR_RD && hit_mode |=> SFR_RDATA[`CMPMS_ZERO_BIT] == 1'b0
            && SFR_RDATA[`CMPMS_ZERO_HI:`CMPMS_ZERO_LO] == 2'b00)
        else $error("unused mode bits read as one");

    a_rise_enable_store: assert property (
        wr_mode |=> CMP1_MODE.rise_edge_irq_enable == $past(SFR_WDATA[`CMPMS_RIE]))
        else $error("rise enable not stored");

    a_fall_enable_store: assert property (
        wr_mode |=> CMP1_MODE.fall_edge_irq_enable == $past(SFR_WDATA[`CMPMS_FIE]))
        else $error("fall enable not stored");

    a_power_mode_store: assert property (
        wr_mode |=> CMP1_MODE.response_power_mode == $past(SFR_WDATA[`CMPMS_MD_HI:`CMPMS_MD_LO]))
        else $error("mode field not stored");

    a_neg_select_store: assert property (
        wr_mux |=> CMP0_MUX.negative_input_select == $past(SFR_WDATA[`CMPMS_NEG_HI:`CMPMS_NEG_LO]))
        else $error("negative select not stored");

    a_pos_select_store: assert property (
        wr_mux |=> CMP0_MUX.positive_input_select == $past(SFR_WDATA[`CMPMS_POS_HI:`CMPMS_POS_LO]))
        else $error("positive select not stored");

    a_capture_route: assert property (
        ##1 TMR_CAP[0] == (
            $past(CAP_SRC_SEL[0]) ? $past(cmp_sync[1]) : $past(cmp_sync[0])))
        else $error("capture source wrong");

    a_touch_pin_link: assert property (
        pos_sel == `CMPMS_CODE_TOUCH && neg_sel == 4'h0 |=> TOUCH_NEG_PIN_EN)
        else $error("touch pin not linked");

    a_half_div_gate: assert property (
        HALF_DIV_EN |-> $past(neg_sel) == `CMPMS_CODE_HALF
            || $past(pos_sel) == `CMPMS_CODE_HALF)
        else $error("divider on while not selected");

    a_edge_sets_flag: assert property (
        rise_evt |=> RISE_FLAG ##1 (RISE_FLAG || $past(RISE_FLAG_CLR)))
        else $error("rising edge lost");

    a_irq_from_flags: assert property (
        RISE_FLAG && CMP1_MODE.rise_edge_irq_enable |=> CMP1_IRQ)
        else $error("request missing for enabled flag");

    // Flag stickiness, the request in both directions and the last timer's capture route
    a_fall_sets_flag: assert property (
        fall_evt |=> FALL_FLAG ##1 (FALL_FLAG || $past(FALL_FLAG_CLR)))
        else $error("falling edge lost");

    a_rise_flag_holds: assert property (
        RISE_FLAG && !RISE_FLAG_CLR |=> RISE_FLAG)
        else $error("rise flag dropped without clear");

    a_irq_from_fall: assert property (
        FALL_FLAG && CMP1_MODE.fall_edge_irq_enable |=> CMP1_IRQ)
        else $error("request missing for enabled fall flag");

    a_irq_needs_flag: assert property (
        CMP1_IRQ |-> $past(RISE_FLAG && CMP1_MODE.rise_edge_irq_enable
            || FALL_FLAG && CMP1_MODE.fall_edge_irq_enable))
        else $error("request without an enabled flag");

    a_capture_route_top: assert property (
        ##1 TMR_CAP[N_CAP-1] == (
            $past(CAP_SRC_SEL[N_CAP-1]) ? $past(cmp_sync[1]) : $past(cmp_sync[0])))
        else $error("capture source wrong on last timer");

    c_rise_irq: cover property (rise_evt ##1 RISE_FLAG ##1 CMP1_IRQ);
    c_fall_clear: cover property (FALL_FLAG && FALL_FLAG_CLR);
    c_touch_mode: cover property (TOUCH_POS_PIN_EN);
    c_half_div: cover property (HALF_DIV_EN);

endmodule // cmpms_top

// ===== verif/cmpms_top_tb.sv
/*
 Self-checking bench for the comparator mode and input select bank.
 Assumes the design package and cmpms_params.svh are compiled first.
*/
`timescale 1ns/1ps
`include "cmpms_params.svh"

module cmpms_top_tb;
    import cmpms_pkg::*;

    // Stimulus, driven at the falling edge
    logic REF_CLK = 0, NRST = 0, SFR_WR = 0, SFR_RD = 0, CMP0_OUT = 0, CMP1_OUT = 0;
    logic RISE_FLAG_CLR = 0, FALL_FLAG_CLR = 0;
    logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0;
    logic [1:0] CAP_SRC_SEL = 0;
    // Observed outputs
    logic [7:0] SFR_RDATA;
    logic SFR_RHIT, TOUCH_NEG_PIN_EN, TOUCH_POS_PIN_EN, HALF_DIV_EN, RISE_FLAG, FALL_FLAG, CMP1_IRQ;
    logic [1:0] TMR_CAP;
    cmpms_mode_t CMP1_MODE;
    cmpms_mux_t CMP0_MUX;
    // Bookkeeping
    int error_cnt = 0, tests_run = 0;
    logic [7:0] d, v;
    logic h;

    cmpms_top #(.N_CAP(2)) u_cmpms_top (
        .REF_CLK(REF_CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
        .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_RHIT(SFR_RHIT), .CMP0_OUT(CMP0_OUT),
        .CMP1_OUT(CMP1_OUT), .RISE_FLAG_CLR(RISE_FLAG_CLR), .FALL_FLAG_CLR(FALL_FLAG_CLR),
        .CAP_SRC_SEL(CAP_SRC_SEL), .CMP1_MODE(CMP1_MODE), .CMP0_MUX(CMP0_MUX),
        .TOUCH_NEG_PIN_EN(TOUCH_NEG_PIN_EN), .TOUCH_POS_PIN_EN(TOUCH_POS_PIN_EN),
        .HALF_DIV_EN(HALF_DIV_EN), .RISE_FLAG(RISE_FLAG), .FALL_FLAG(FALL_FLAG),
        .CMP1_IRQ(CMP1_IRQ), .TMR_CAP(TMR_CAP)
    );

    // 250 MHz clock
    initial begin
        forever #2 REF_CLK = ~REF_CLK;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Four-state compare, so an unknown never matches
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Idle falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge REF_CLK);
        SFR_ADDR = a;
        SFR_WDATA = dat;
        SFR_WR = 1;
        @(negedge REF_CLK);
        SFR_WR = 0;
    endtask

    // One-cycle read strobe; data is registered by the edge in between
    task automatic rd(input logic [7:0] a);
        @(negedge REF_CLK);
        SFR_ADDR = a;
        SFR_RD = 1;
        @(negedge REF_CLK);
        SFR_RD = 0;
        d = SFR_RDATA;
        h = SFR_RHIT;
    endtask

    // Expected {touch_neg, touch_pos, half} for a select value
    function automatic logic [2:0] side_exp(input logic [7:0] m);
        logic [15:0] nm, pm;
        nm = `CMPMS_NEG_PIN_MASK;
        pm = `CMPMS_POS_PIN_MASK;
        return {m[3:0] == 4'hc && nm[m[7:4]], m[7:4] == 4'hc && pm[m[3:0]], m[7:4] == 4'hd || m[3:0] == 4'hd};
    endfunction

    // Hang guard
    initial begin
        repeat (100000) @(posedge REF_CLK);
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        void'($urandom(32'h84b646dd));
        cyc(6);
        NRST = 1;
        // Reset values and an unmapped read
        rd(8'h9c);
        chk(d, 8'h82, "mode reset");
        chk({4'h0, CMP1_MODE}, 8'h02, "mode field reset");
        rd(8'h9f);
        chk(d, 8'hff, "mux reset");
        chk({7'h0, h}, 8'h01, "hit");
        chk({5'h0, TOUCH_NEG_PIN_EN, TOUCH_POS_PIN_EN, HALF_DIV_EN}, 8'h00, "side reset");
        rd(8'h9d);
        chk({d[6:0], h}, 8'h00, "unmapped read");
        $display("test reset done");
        // Mode register: every speed code, random loose bits
        for (int i = 0; i < 12; i++) begin
            v = 8'($urandom);
            if (i < 4) v[1:0] = i[1:0];
            v[`CMPMS_FIXED_HI] = 1'b1;
            wr(8'h9c, v);
            rd(8'h9c);
            chk(d, 8'h80 | (v & 8'h33), "mode read");
            chk({4'h0, CMP1_MODE}, {4'h0, v[5:4], v[1:0]}, "mode out");
        end
        wr(8'h9d, 8'h00);
        rd(8'h9c);
        chk(d, 8'h80 | (v & 8'h33), "unmapped write ignored");
        $display("test mode done");
        // Input select: all codes opposite the touch code, then random
        for (int i = 0; i < 44; i++) begin
            v = (i < 16) ? {i[3:0], 4'hc} : (i < 32) ? {4'hc, i[3:0]} : 8'($urandom);
            // Pins named by the codes are taken as set analogue by software
            wr(8'h9f, v);
            rd(8'h9f);
            chk(d, v, "mux read");
            chk(CMP0_MUX, v, "mux out");
            chk({5'h0, TOUCH_NEG_PIN_EN, TOUCH_POS_PIN_EN, HALF_DIV_EN}, {5'h0, side_exp(v)}, "side");
        end
        $display("test mux done");
        // Edge flags and interrupt request
        wr(8'h9c, 8'hb0);
        CMP1_OUT = 1;
        cyc(5);
        chk({6'h0, RISE_FLAG, FALL_FLAG}, 8'h02, "rise flag");
        chk({7'h0, CMP1_IRQ}, 8'h01, "rise irq");
        RISE_FLAG_CLR = 1;
        cyc(1);
        RISE_FLAG_CLR = 0;
        cyc(1);
        chk({6'h0, RISE_FLAG, CMP1_IRQ}, 8'h00, "rise cleared");
        CMP1_OUT = 0;
        cyc(5);
        chk({6'h0, FALL_FLAG, CMP1_IRQ}, 8'h03, "fall irq");
        wr(8'h9c, 8'h80);
        cyc(1);
        chk({6'h0, FALL_FLAG, CMP1_IRQ}, 8'h02, "irq masked");
        FALL_FLAG_CLR = 1;
        cyc(1);
        FALL_FLAG_CLR = 0;
        // Clear landing on the same edge as a new rise: set wins
        wr(8'h9c, 8'ha0);
        CMP1_OUT = 1;
        cyc(2);
        RISE_FLAG_CLR = 1;
        cyc(1);
        RISE_FLAG_CLR = 0;
        cyc(2);
        chk({6'h0, RISE_FLAG, CMP1_IRQ}, 8'h03, "set over clear");
        $display("test flags done");
        // Capture routing, random sources and levels
        for (int i = 0; i < 16; i++) begin
            CMP0_OUT = 1'($urandom);
            CMP1_OUT = 1'($urandom);
            CAP_SRC_SEL = 2'($urandom);
            cyc(4);
            for (int t = 0; t < 2; t++) begin
                chk({7'h0, TMR_CAP[t]}, {7'h0, CAP_SRC_SEL[t] ? CMP1_OUT : CMP0_OUT}, "capture");
            end
        end
        $display("test capture done");
        // Reset in mid-run restores the mode register; a high comparator is no edge
        CMP1_OUT = 1;
        NRST = 0;
        cyc(2);
        NRST = 1;
        rd(8'h9c);
        chk(d, 8'h82, "mode after reset");
        cyc(3);
        chk({6'h0, RISE_FLAG, FALL_FLAG}, 8'h00, "no edge from reset");
        $display("test rereset done");
        close_out();
    end
endmodule // cmpms_top_tb
